/* tb_tsp_ports.sv */
// self-checking bench of the highway and serial audio ports
`include "tsp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_tsp_ports;
	import tsp_pkg::*;
	logic clk, rstn, hw_clk, hw_fs, dd_line, du_line, dd_o, dd_oe, du_o, du_oe;
	logic sclk_o, sclk_oe, st_o, st_oe, rfs_o, rfs_oe, tfs_o, tfs_oe, wr_en, c_p, r_p, t_p;
	logic st_line;
	tsp_hw_cfg_type hw_cfg;
	tsp_sa_cfg_type sa_cfg;
	tsp_ch_cfg_type [`TSP_USR_N-1:0] ch_cfg;
	logic [1:0] burst_go;
	logic [3:0] wr_ch, rd_ch;
	logic [31:0] wr_data, rd_data, d;
	logic [`TSP_CH_N-1:0] ch_irq;
	logic [7:0] tx_byte;
	logic [63:0] cap_du, cap_oe, ev, eo;
	int n_frames, n_errors, samples_checked, cyc, n_irq, n0;
	int q_c[$], q_r[$], qw_r[$], q_t[$];
	// =====================================
	// design and peer
	tsp_ports i_tsp_ports (.clk(clk), .rstn(rstn), .highway_bit_clock(hw_clk),
		.highway_frame_sync(hw_fs), .highway_data_down_i(dd_line),
		.highway_data_down_o(dd_o), .highway_data_down_oe(dd_oe),
		.highway_data_up_i(du_line), .highway_data_up_o(du_o), .highway_data_up_oe(du_oe),
		.sa_clk_i(1'b0), .sa_clk_o(sclk_o), .sa_clk_oe(sclk_oe),
		.serial_audio_receive_line(st_line), .serial_audio_transmit_line_o(st_o),
		.serial_audio_transmit_line_oe(st_oe), .receive_frame_sync_i(tfs_o),
		.receive_frame_sync_o(rfs_o), .receive_frame_sync_oe(rfs_oe),
		.transmit_frame_sync_i(1'b0), .transmit_frame_sync_o(tfs_o),
		.transmit_frame_sync_oe(tfs_oe), .hw_cfg(hw_cfg), .sa_cfg(sa_cfg), .ch_cfg(ch_cfg),
		.burst_go(burst_go), .wr_en(wr_en), .wr_ch(wr_ch), .wr_data(wr_data), .rd_ch(rd_ch),
		.rd_data(rd_data), .ch_irq(ch_irq));
	tsp_hw_peer i_tsp_hw_peer (.clk(clk), .rstn(rstn), .hw_clk(hw_clk), .hw_fs(hw_fs),
		.dd_o(dd_o), .dd_oe(dd_oe), .du_o(du_o), .du_oe(du_oe), .dd_line(dd_line),
		.du_line(du_line), .tx_byte(tx_byte), .cap_du(cap_du), .cap_oe(cap_oe),
		.n_frames(n_frames));
	// serial transmit looped back to receive, pulled up when released
	assign st_line = st_oe ? st_o : 1'b1;
	// =====================================
	// clock, monitors and timeout
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (ch_irq[0] === 1'b1) n_irq++;
		if (sclk_o === 1'b1 && c_p === 1'b0) q_c.push_back(cyc);
		if (rfs_o === 1'b1 && r_p === 1'b0) q_r.push_back(cyc);
		if (rfs_o === 1'b0 && r_p === 1'b1) qw_r.push_back(cyc - q_r[$]);
		if (tfs_o === 1'b1 && t_p === 1'b0) q_t.push_back(cyc);
		c_p = sclk_o;
		r_p = rfs_o;
		t_p = tfs_o;
		if (cyc == 60000) begin
			n_errors++;
			end_sim();
		end
	end
	// =====================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wait_frames(input int n);
		int f;
		f = n_frames;
		while (n_frames < f + n) tick(1);
	endtask : wait_frames
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected word at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_line(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected line at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_line
	task automatic chk_cnt(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			n_errors++;
			$display("unexpected count at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// =====================================
	// main sequence
	initial begin
		rstn = 1'b0;
		hw_cfg = '0;
		hw_cfg.mon_mux = 4'h0;
		hw_cfg.ci_mux = 8'hff;
		sa_cfg = '0;
		for (int i = 0; i < `TSP_USR_N; i++) begin
			ch_cfg[i] = '{TSP_LINE_DOWN, 10'h1f4, 9'h008, 1'b0, 6'h08};
		end
		ch_cfg[0].start = 10'h001;
		ch_cfg[2].line = TSP_LINE_UP;
		ch_cfg[2].start = 10'h003;
		{burst_go, wr_en, wr_ch, wr_data, rd_ch, tx_byte} = '0;
		void'($urandom(32'h0935));
		tick(2);
		chk_word({dd_oe, du_oe, st_oe, sclk_o, ch_irq}, 32'h0);
		rstn = 1'b1;
		tick(2);
		for (int k = 0; k < 2; k++) begin
			d = $urandom;
			{wr_en, wr_ch, wr_data} = {1'b1, 4'h2, d};
			tick(1);
			wr_en = 1'b0;
			rd_ch = 4'h2;
			tick(2);
			chk_word(rd_data, d);
		end
		rd_ch = 4'he;
		tick(2);
		chk_word(rd_data, 32'h0);
		$display("test sample port done");
		for (int s = 0; s < 2; s++) begin
			hw_cfg.capture_sel = s[0];
			hw_cfg.open_drain = {2{s[0]}};
			d = $urandom;
			tx_byte = 8'($urandom);
			{wr_en, wr_ch, wr_data} = {1'b1, 4'h2, d};
			tick(1);
			wr_en = 1'b0;
			wait_frames(2);
			for (int i = 0; i < 64; i++) begin
				// audio slot bits 3-10, monitor slot bits 17-24 sending zeros
				eo[i] = (i >= 2 && i <= 9) || (i >= 16 && i <= 23);
				ev[i] = (i >= 2 && i <= 9) ? d[33 - i] : !eo[i];
				eo[i] = eo[i] && !(s[0] && ev[i]);
			end
			chk_line(cap_du, ev);
			chk_line(cap_oe, eo);
			n_irq = 0;
			wait_frames(1);
			tick(16);
			rd_ch = 4'h0;
			tick(2);
			chk_word({24'h0, rd_data[7:0]}, {24'h0, tx_byte});
			chk_cnt(n_irq, 2);
		end
		$display("test highway done");
		sa_cfg.clk_out = 1'b1;
		sa_cfg.fs_out = 2'b11;
		sa_cfg.cont = 2'b01;
		for (int p = 0; p < 2; p++) begin
			sa_cfg.div = 10'(p * 2);
			sa_cfg.sync_period_value[0] = 8'(p);
			tick(600);
			chk_cnt(q_c[$] - q_c[$-1], 2 * (p * 2 + 1));
			chk_cnt(q_r[$] - q_r[$-1], 16 * (p + 1) * 2 * (p * 2 + 1));
			chk_cnt(qw_r[$], 2 * (p * 2 + 1));
		end
		sa_cfg.div = 10'h000;
		sa_cfg.burst_repeat_value[1] = 10'h002;
		tick(20);
		n0 = q_t.size();
		burst_go = 2'b10;
		tick(1);
		burst_go = 2'b00;
		tick(400);
		chk_cnt(q_t.size() - n0, 3);
		chk_cnt(q_t[$] - q_t[$-1], 32);
		$display("test serial port done");
		// transmit sync runs every 16 bits and also feeds the receive sync input
		sa_cfg.fs_out = 2'b10;
		sa_cfg.cont = 2'b10;
		ch_cfg[0] = '{TSP_LINE_SERIAL, 10'h001, 9'h008, 1'b1, 6'h01};
		ch_cfg[1] = '{TSP_LINE_SERIAL, 10'h001, 9'h008, 1'b0, 6'h08};
		ch_cfg[3] = ch_cfg[1];
		d = $urandom;
		{wr_en, wr_ch, wr_data} = {1'b1, 4'h3, d};
		tick(1);
		wr_en = 1'b0;
		rd_ch = 4'h1;
		tick(200);
		chk_word({24'h0, rd_data[7:0]}, {24'h0, d[31:24]});
		n_irq = 0;
		tick(128);
		chk_cnt(n_irq, 32);
		$display("test serial loopback done");
		end_sim();
	end
endmodule : tb_tsp_ports
`default_nettype wire

/* tsp_hw_peer.sv */
// highway peer model: bit clock, frame sync, down line data, up line capture
`timescale 1ns/1ps
`default_nettype none
module tsp_hw_peer (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// highway
	output logic hw_clk,
	output logic hw_fs,
	input wire logic dd_o,
	input wire logic dd_oe,
	input wire logic du_o,
	input wire logic du_oe,
	output logic dd_line,
	output logic du_line,
	// test access
	input wire logic [7:0] tx_byte,
	output logic [63:0] cap_du,
	output logic [63:0] cap_oe,
	output int n_frames
);
	logic [5:0] ph;
	logic [5:0] bitn;
	logic [5:0] nb;
	logic peer_d;
	// =====================================
	// clock, sync and line levels
	// one bit is 64 clk, two bit clock periods
	assign hw_clk = ~ph[4];
	assign hw_fs = (bitn == 6'h00);
	assign dd_line = dd_oe ? dd_o : peer_d;
	// up line has a pull-up when released
	assign du_line = du_oe ? du_o : 1'b1;
	assign nb = bitn + 6'h01;
	// =====================================
	// launch on bit clock rise, capture at 7/8 bit
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// start with the bit clock low, as the design's edge detector resets
			ph <= 6'h10;
			bitn <= 6'h3f;
			peer_d <= 1'b1;
			n_frames <= 0;
		end else begin
			ph <= ph + 6'h01;
			if (ph == 6'h3f) begin
				bitn <= nb;
				peer_d <= (nb < 6'h08) ? tx_byte[3'h7 - nb[2:0]] : 1'($urandom);
			end
			if (ph == 6'h38) begin
				cap_du[bitn] <= du_line;
				cap_oe[bitn] <= du_oe;
				if (bitn == 6'h3f) begin
					n_frames <= n_frames + 1;
				end
			end
		end
	end
endmodule : tsp_hw_peer
`default_nettype wire

/* tsp_params.svh */
// timing, layout and reset constants of the highway and serial audio ports
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH
`define TSP_CH_N 14
`define TSP_USR_N 8
`define TSP_TX_MASK 14'h2acc
`define TSP_MON_OFS 10'h011
`define TSP_CI_OFS 10'h01b
`define TSP_MON_LEN 9'h008
`define TSP_CI_LEN_LONG 9'h006
`define TSP_CI_LEN_SHORT 9'h004
`define TSP_BURST_GAP 12'h00f
`define TSP_CNT_MAX 11'h7ff
`define TSP_STATE_RST '0
`endif

/* tsp_pkg.sv */
// types shared by the highway and serial audio port logic
`include "tsp_params.svh"
package tsp_pkg;
	typedef enum logic [1:0] {
		TSP_LINE_DOWN = 2'h0,
		TSP_LINE_UP = 2'h1,
		TSP_LINE_SERIAL = 2'h2
	} tsp_line_type;
	typedef struct packed {
		tsp_line_type line;
		logic [9:0] start;
		logic [8:0] len;
		logic cnt_mode;
		logic [5:0] cnt_bits;
	} tsp_ch_cfg_type;
	typedef struct packed {
		logic single_rate;
		logic standalone;
		logic capture_sel;
		logic [1:0] open_drain;
		logic mon_dir;
		logic [3:0] mon_mux;
		logic ci_dir;
		logic ci_six;
		logic [1:0][3:0] ci_mux;
	} tsp_hw_cfg_type;
	typedef struct packed {
		logic clk_out;
		logic strobe;
		logic invert;
		logic [9:0] div;
		logic [1:0] fs_out;
		logic [1:0] fs_fall;
		logic [1:0] cont;
		logic [1:0][7:0] sync_period_value;
		logic [1:0][9:0] burst_repeat_value;
	} tsp_sa_cfg_type;
	typedef struct packed {
		logic hw_clk;
		logic hw_fs;
		logic hw_half;
		logic hw_fall1;
		logic [10:0] hw_cnt;
		logic [9:0] div;
		logic sclk;
		logic sclk_oe;
		logic sclk_in;
		logic [1:0] fs_smp;
		logic [1:0] fs_o;
		logic [1:0] fs_oe;
		logic [1:0][11:0] sp;
		logic [1:0][10:0] rem;
		logic [10:0] rcnt;
		logic [10:0] tcnt;
		logic [`TSP_CH_N-1:0][31:0] sh;
		logic [`TSP_CH_N-1:0][31:0] buff;
		logic [`TSP_CH_N-1:0][5:0] bc;
		logic [`TSP_CH_N-1:0] irq;
		logic dd_o;
		logic dd_oe;
		logic du_o;
		logic du_oe;
		logic st_o;
		logic st_oe;
		logic [31:0] rd;
	} tsp_state_type;
endpackage : tsp_pkg

/* tsp_ports.sv */
// tdm highway and serial audio port engine with channel sample buffers
`include "tsp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tsp_ports (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// highway
	input wire logic highway_bit_clock,
	input wire logic highway_frame_sync,
	input wire logic highway_data_down_i,
	output logic highway_data_down_o,
	output logic highway_data_down_oe,
	input wire logic highway_data_up_i,
	output logic highway_data_up_o,
	output logic highway_data_up_oe,
	// serial audio port
	input wire logic sa_clk_i,
	output logic sa_clk_o,
	output logic sa_clk_oe,
	input wire logic serial_audio_receive_line,
	output logic serial_audio_transmit_line_o,
	output logic serial_audio_transmit_line_oe,
	input wire logic receive_frame_sync_i,
	output logic receive_frame_sync_o,
	output logic receive_frame_sync_oe,
	input wire logic transmit_frame_sync_i,
	output logic transmit_frame_sync_o,
	output logic transmit_frame_sync_oe,
	// configuration
	input wire tsp_pkg::tsp_hw_cfg_type hw_cfg,
	input wire tsp_pkg::tsp_sa_cfg_type sa_cfg,
	input wire tsp_pkg::tsp_ch_cfg_type [`TSP_USR_N-1:0] ch_cfg,
	input wire logic [1:0] burst_go,
	// sample access
	input wire logic wr_en,
	input wire logic [3:0] wr_ch,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] rd_ch,
	output logic [31:0] rd_data,
	output logic [`TSP_CH_N-1:0] ch_irq
);
	import tsp_pkg::*;

	localparam logic [`TSP_CH_N-1:0] TX_MASK = `TSP_TX_MASK;

	tsp_state_type s_q;
	tsp_state_type s_d;
	tsp_ch_cfg_type cc;
	logic dbl, hw_rise, hw_fall, hw_frame, hw_launch, hw_cap;
	logic sa_run, sa_tog, sa_rise, sa_fall, sa_launch, sa_cap;
	logic [1:0] fs_val, sync, fs_edge, emit;
	logic dd_act, du_act, st_act, dd_bit, du_bit, st_bit;
	logic ev_frame, ev_cap, ev_launch, bitv;
	logic [10:0] cap_cnt, lau_cnt;
	logic [31:0] sh_t;

	function automatic logic in_slot(input logic [10:0] c, input logic [9:0] st,
			input logic [8:0] ln);
		in_slot = (c >= {1'b0, st}) && (c < ({1'b0, st} + {2'b0, ln}));
	endfunction : in_slot

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.irq = '0;
		cc = '0;
		sh_t = '0;
		bitv = 1'b0;
		ev_frame = 1'b0;
		ev_cap = 1'b0;
		ev_launch = 1'b0;
		cap_cnt = '0;
		lau_cnt = '0;
		dd_act = 1'b0;
		du_act = 1'b0;
		st_act = 1'b0;
		dd_bit = 1'b0;
		du_bit = 1'b0;
		st_bit = 1'b0;
		emit = '0;
		// highway bit timing
		s_d.hw_clk = highway_bit_clock;
		hw_rise = highway_bit_clock & ~s_q.hw_clk;
		hw_fall = ~highway_bit_clock & s_q.hw_clk;
		dbl = hw_cfg.standalone | ~hw_cfg.single_rate;
		hw_frame = hw_rise & highway_frame_sync & ~s_q.hw_fs;
		hw_launch = hw_rise & (hw_frame | ~dbl | ~s_q.hw_half);
		hw_cap = hw_fall & (~dbl | (s_q.hw_fall1 == ~hw_cfg.capture_sel));
		if (hw_rise) begin
			s_d.hw_fs = highway_frame_sync;
			s_d.hw_half = hw_launch;
		end
		if (hw_launch) begin
			s_d.hw_fall1 = 1'b0;
		end else if (hw_fall) begin
			s_d.hw_fall1 = 1'b1;
		end
		if (hw_frame) begin
			s_d.hw_cnt = 11'h001;
		end else if (hw_launch && s_q.hw_cnt != `TSP_CNT_MAX) begin
			s_d.hw_cnt = s_q.hw_cnt + 11'h001;
		end
		// serial clock divider, held in strobed mode when no burst pends
		sa_run = ~sa_cfg.strobe | (s_q.rem[0] != '0) | (s_q.rem[1] != '0);
		sa_tog = 1'b0;
		s_d.sclk_oe = sa_cfg.clk_out;
		s_d.sclk_in = sa_clk_i;
		if (sa_cfg.clk_out && sa_run) begin
			if (s_q.div == sa_cfg.div) begin
				s_d.div = '0;
				s_d.sclk = ~s_q.sclk;
				sa_tog = 1'b1;
			end else begin
				s_d.div = s_q.div + 10'h001;
			end
		end else begin
			s_d.div = '0;
		end
		sa_rise = sa_cfg.clk_out ? (sa_tog & ~s_q.sclk) : (sa_clk_i & ~s_q.sclk_in);
		sa_fall = sa_cfg.clk_out ? (sa_tog & s_q.sclk) : (~sa_clk_i & s_q.sclk_in);
		sa_launch = sa_cfg.invert ? sa_fall : sa_rise;
		sa_cap = sa_cfg.invert ? sa_rise : sa_fall;
		// frame syncs, own outputs sampled like inputs
		fs_val[0] = sa_cfg.fs_out[0] ? s_q.fs_o[0] : receive_frame_sync_i;
		fs_val[1] = sa_cfg.fs_out[1] ? s_q.fs_o[1] : transmit_frame_sync_i;
		s_d.fs_oe = sa_cfg.fs_out;
		for (int k = 0; k < 2; k++) begin
			if (sa_fall) begin
				s_d.fs_smp[k] = fs_val[k];
			end
			sync[k] = sa_fall & fs_val[k] & ~s_q.fs_smp[k];
			fs_edge[k] = sa_cfg.fs_fall[k] ? sa_fall : sa_rise;
			if (burst_go[k]) begin
				s_d.rem[k] = {1'b0, sa_cfg.burst_repeat_value[k]} + 11'h001;
				s_d.sp[k] = '0;
			end else if (fs_edge[k]) begin
				if (s_q.sp[k] != '0) begin
					s_d.sp[k] = s_q.sp[k] - 12'h001;
				end else if (sa_cfg.cont[k]) begin
					emit[k] = 1'b1;
					s_d.sp[k] = {sa_cfg.sync_period_value[k], 4'hf};
				end else if (s_q.rem[k] != '0) begin
					emit[k] = 1'b1;
					s_d.rem[k] = s_q.rem[k] - 11'h001;
					s_d.sp[k] = `TSP_BURST_GAP;
				end
				s_d.fs_o[k] = emit[k] & sa_cfg.fs_out[k];
			end
		end
		// serial line bit counters
		if (sync[0]) begin
			s_d.rcnt = 11'h001;
		end else if (sa_cap && s_q.rcnt != `TSP_CNT_MAX) begin
			s_d.rcnt = s_q.rcnt + 11'h001;
		end
		if (sync[1]) begin
			s_d.tcnt = '0;
		end else if (sa_launch && s_q.tcnt != `TSP_CNT_MAX) begin
			s_d.tcnt = s_q.tcnt + 11'h001;
		end
		// channel engines
		for (int i = 0; i < `TSP_CH_N; i++) begin
			cc = '0;
			if (i < `TSP_USR_N) begin
				cc = ch_cfg[3'(i)];
			end else if (i < 10) begin
				cc.line = (hw_cfg.mon_dir ^ TX_MASK[i]) ? TSP_LINE_UP : TSP_LINE_DOWN;
				cc.start = {1'b0, hw_cfg.mon_mux, 5'h00} + `TSP_MON_OFS;
				cc.len = `TSP_MON_LEN;
			end else begin
				cc.line = (hw_cfg.ci_dir ^ TX_MASK[i]) ? TSP_LINE_UP : TSP_LINE_DOWN;
				cc.start = {1'b0, hw_cfg.ci_mux[1'((i - 10) / 2)], 5'h00} + `TSP_CI_OFS;
				cc.len = hw_cfg.ci_six ? `TSP_CI_LEN_LONG : `TSP_CI_LEN_SHORT;
			end
			if (cc.line == TSP_LINE_SERIAL) begin
				ev_frame = TX_MASK[i] ? sync[1] : sync[0];
				ev_cap = sa_cap;
				ev_launch = sa_launch;
				cap_cnt = s_q.rcnt;
				lau_cnt = s_d.tcnt;
				bitv = serial_audio_receive_line;
			end else begin
				ev_frame = hw_frame;
				ev_cap = hw_cap;
				ev_launch = hw_launch;
				cap_cnt = s_q.hw_cnt;
				lau_cnt = s_d.hw_cnt;
				bitv = (cc.line == TSP_LINE_UP) ? highway_data_up_i : highway_data_down_i;
			end
			sh_t = s_q.sh[i];
			if (!TX_MASK[i]) begin
				if (ev_frame && !cc.cnt_mode) begin
					s_d.buff[i] = s_q.sh[i];
					s_d.irq[i] = 1'b1;
				end
				if (ev_cap && in_slot(cap_cnt, cc.start, cc.len)) begin
					sh_t = {s_q.sh[i][30:0], bitv};
					if (cc.cnt_mode) begin
						if (s_q.bc[i] + 6'h01 == cc.cnt_bits) begin
							s_d.buff[i] = sh_t;
							s_d.bc[i] = '0;
							s_d.irq[i] = 1'b1;
						end else begin
							s_d.bc[i] = s_q.bc[i] + 6'h01;
						end
					end
				end
			end else begin
				if (ev_frame && !cc.cnt_mode) begin
					sh_t = s_q.buff[i];
					s_d.irq[i] = 1'b1;
				end
				if (ev_launch && in_slot(lau_cnt, cc.start, cc.len)) begin
					unique case (cc.line)
						TSP_LINE_DOWN: begin
							dd_act = 1'b1;
							dd_bit = dd_bit | sh_t[31];
						end
						TSP_LINE_UP: begin
							du_act = 1'b1;
							du_bit = du_bit | sh_t[31];
						end
						default: begin
							st_act = 1'b1;
							st_bit = st_bit | sh_t[31];
						end
					endcase
					sh_t = {sh_t[30:0], 1'b0};
					if (cc.cnt_mode) begin
						if (s_q.bc[i] + 6'h01 == cc.cnt_bits) begin
							sh_t = s_q.buff[i];
							s_d.bc[i] = '0;
							s_d.irq[i] = 1'b1;
						end else begin
							s_d.bc[i] = s_q.bc[i] + 6'h01;
						end
					end
				end
			end
			s_d.sh[i] = sh_t;
		end
		// line drivers, floating outside own slots
		if (hw_launch) begin
			s_d.dd_oe = dd_act & (~hw_cfg.open_drain[0] | ~dd_bit);
			s_d.dd_o = dd_bit & ~hw_cfg.open_drain[0];
			s_d.du_oe = du_act & (~hw_cfg.open_drain[1] | ~du_bit);
			s_d.du_o = du_bit & ~hw_cfg.open_drain[1];
		end
		if (sa_launch) begin
			s_d.st_oe = st_act;
			s_d.st_o = st_bit;
		end
		// sample access; only transmit buffers are writable
		if (wr_en && wr_ch < 4'(`TSP_CH_N) && TX_MASK[wr_ch]) begin
			s_d.buff[wr_ch] = wr_data;
		end
		s_d.rd = (rd_ch < 4'(`TSP_CH_N)) ? s_q.buff[rd_ch] : '0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= `TSP_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs
	assign highway_data_down_o = s_q.dd_o;
	assign highway_data_down_oe = s_q.dd_oe;
	assign highway_data_up_o = s_q.du_o;
	assign highway_data_up_oe = s_q.du_oe;
	assign sa_clk_o = s_q.sclk;
	assign sa_clk_oe = s_q.sclk_oe;
	assign serial_audio_transmit_line_o = s_q.st_o;
	assign serial_audio_transmit_line_oe = s_q.st_oe;
	assign receive_frame_sync_o = s_q.fs_o[0];
	assign receive_frame_sync_oe = s_q.fs_oe[0];
	assign transmit_frame_sync_o = s_q.fs_o[1];
	assign transmit_frame_sync_oe = s_q.fs_oe[1];
	assign rd_data = s_q.rd;
	assign ch_irq = s_q.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	frame_cnt_a: assert property (hw_frame |=> s_q.hw_cnt == 11'h001)
		else $error("highway bit counter not restarted by frame sync");
	frame_edge_a: assert property (hw_frame |-> hw_launch && !$past(highway_frame_sync))
		else $error("frame start without sync rise");
	line_float_a: assert property (hw_launch && !dd_act && !du_act |=>
		!s_q.dd_oe && !s_q.du_oe)
		else $error("highway line driven outside own slot");
	open_drain_a: assert property (hw_launch && hw_cfg.open_drain[0] |=> !s_q.dd_o)
		else $error("open drain line driven high");
	launch_edge_a: assert property ($changed(s_q.dd_oe) |-> $past(hw_rise))
		else $error("highway data changed off rising clock");
	late_capture_a: assert property (hw_cap && dbl && !hw_cfg.capture_sel |-> s_q.hw_fall1)
		else $error("late capture taken on first falling edge");
	clk_divider_a: assert property (sa_cfg.clk_out && $changed(s_q.sclk) |->
		$past(s_q.div) == $past(sa_cfg.div))
		else $error("serial clock toggled at wrong divider count");
	sync_sample_a: assert property ($changed(s_q.fs_smp) |-> $past(sa_fall))
		else $error("frame sync sampled off falling edge");
	fs_edge_a: assert property ($rose(s_q.fs_o[0]) |-> $past(fs_edge[0]))
		else $error("frame sync rose off selected edge");
	cont_gap_a: assert property (fs_edge[0] && s_q.sp[0] == '0 && sa_cfg.cont[0]
		&& !burst_go[0] |=> s_q.sp[0] == {$past(sa_cfg.sync_period_value[0]), 4'hf})
		else $error("continuous sync spacing wrong");
	burst_load_a: assert property (burst_go[1] |=>
		s_q.rem[1] == {1'b0, $past(sa_cfg.burst_repeat_value[1])} + 11'h001)
		else $error("burst count not loaded");
endmodule : tsp_ports
`default_nettype wire
